// ==== src/orps_overrange_preset.sv ====
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module orps_overrange_preset
   import orps_pkg::*;
#(
   parameter int unsigned SAMPLE_W = 16,
   parameter int unsigned FREQ_W = 32,
   parameter int unsigned PHASE_W = 16
) (
   input wire logic i_clk_sys, // device clock
   input wire logic i_srst, // sync reset, active high
   input wire logic i_psel, // apb select
   input wire logic i_penable, // apb enable
   input wire logic i_pwrite, // apb direction
   input wire logic [ADDR_W-1:0] i_paddr, // apb byte address
   input wire logic [31:0] i_pwdata, // apb write data
   input wire logic [3:0] i_pstrb, // apb byte strobes
   output logic o_pready, // apb ready
   output logic [31:0] o_prdata, // apb read data
   output logic o_pslverr, // apb error, unmapped address
   input wire logic i_sample_valid, // converter samples valid
   input wire logic [SAMPLE_W-1:0] i_samp_i_a, // converter A I sample
   input wire logic [SAMPLE_W-1:0] i_samp_q_a, // converter A Q sample
   input wire logic [SAMPLE_W-1:0] i_samp_i_b, // converter B I sample
   input wire logic [SAMPLE_W-1:0] i_samp_q_b, // converter B Q sample
   input wire logic [1:0] i_chan_a_preset_pins, // async preset pins A
   input wire logic [1:0] i_chan_b_preset_pins, // async preset pins B
   input wire logic [4*FREQ_W-1:0] i_conv_a_frequency_word, // 4 words A
   input wire logic [4*PHASE_W-1:0] i_conv_a_phase_word, // 4 words A
   input wire logic [4*FREQ_W-1:0] i_conv_b_frequency_word, // 4 words B
   input wire logic [4*PHASE_W-1:0] i_conv_b_phase_word, // 4 words B
   output logic o_chan_a_range_flag_0, // flag pin A, I
   output logic o_chan_a_range_flag_1, // flag pin A, Q
   output logic o_chan_b_range_flag_0, // flag pin B, I
   output logic o_chan_b_range_flag_1, // flag pin B, Q
   output logic [1:0] o_link_ovr_a, // ungated link bits A {q,i}
   output logic [1:0] o_link_ovr_b, // ungated link bits B {q,i}
   output logic [FREQ_W-1:0] o_osc_a_freq, // active freq word A
   output logic [PHASE_W-1:0] o_osc_a_phase, // active phase word A
   output logic [FREQ_W-1:0] o_osc_b_freq, // active freq word B
   output logic [PHASE_W-1:0] o_osc_b_phase, // active phase word B
   output logic o_irq // level interrupt
);

   logic [7:0] i_thr_r;
   logic [7:0] q_thr_r;
   logic [7:0] overrange_pin_config_r;
   logic [7:0] mode_r;
   logic [7:0] sel_r;
   logic [N_EVT-1:0] stat_r;
   logic [N_EVT-1:0] ien_r;
   logic single_r;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic irq_r;
   logic [1:0] pin_a_s1_r;
   logic [1:0] pin_a_s2_r;
   logic [1:0] pin_b_s1_r;
   logic [1:0] pin_b_s2_r;
   logic [1:0] act_a_r;
   logic [1:0] act_b_r;
   logic [1:0] act_a_nxt;
   logic [1:0] act_b_nxt;
   logic [N_FLAG-1:0] det;
   logic [N_FLAG-1:0] det_r;
   logic [N_FLAG-1:0] pin_r;
   logic [CNT_W-1:0] cnt_r [N_FLAG];
   logic [SAMPLE_W-1:0] samp [N_FLAG];
   logic [CNT_W-1:0] stretch_len;
   logic wr_acc;
   logic [9:0] idx;
   logic clr_wr;

   function automatic logic [FREQ_W-1:0] pick_f(
      input logic [4*FREQ_W-1:0] words,
      input logic [1:0] n
   );
      pick_f = words[n*FREQ_W +: FREQ_W];
   endfunction : pick_f

   function automatic logic [PHASE_W-1:0] pick_p(
      input logic [4*PHASE_W-1:0] words,
      input logic [1:0] n
   );
      pick_p = words[n*PHASE_W +: PHASE_W];
   endfunction : pick_p

   // magnitude scaled so that full scale is 256; 9 bits to hold 256 itself
   function automatic logic [8:0] level9(input logic [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] m;
      m = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
      level9 = m[SAMPLE_W-1 -: 9];
   endfunction : level9

   function automatic logic mapped(input logic [9:0] a);
      mapped = (a == IDX_I_THRESH) || (a == IDX_Q_THRESH) ||
         (a == IDX_OVERRANGE_PIN_CONFIG) || (a == IDX_PRESET_MODE) ||
         (a == IDX_PRESET_SEL) || (a == IDX_EVT_STATUS) ||
         (a == IDX_EVT_CLEAR) || (a == IDX_EVT_ENABLE) ||
         (a == IDX_CHAN_MODE) || (a == IDX_LIVE_STATE);
   endfunction : mapped

   // ---------------- apb slave: no wait state, ready in first access cycle, outputs from flops
   assign idx = i_paddr[ADDR_W-1:2];
   assign wr_acc = i_psel && i_penable && pready_r && i_pwrite &&
      i_pstrb[0] && (i_paddr[1:0] == 2'h0) && mapped(idx);
   assign clr_wr = wr_acc && (idx == IDX_EVT_CLEAR);

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= i_psel && !i_penable;
         // error stands only with ready, never lingers into idle
         pslverr_r <= 1'b0;
         if (i_psel && !i_penable) begin
            pslverr_r <= !mapped(idx) || (i_paddr[1:0] != 2'h0);
            prdata_r <= 32'h0000_0000;
            case (idx)
               IDX_I_THRESH: prdata_r[7:0] <= i_thr_r;
               IDX_Q_THRESH: prdata_r[7:0] <= q_thr_r;
               IDX_OVERRANGE_PIN_CONFIG: prdata_r[7:0] <= overrange_pin_config_r;
               IDX_PRESET_MODE: prdata_r[7:0] <= mode_r;
               IDX_PRESET_SEL: prdata_r[7:0] <= sel_r;
               IDX_EVT_STATUS: prdata_r[N_EVT-1:0] <= stat_r;
               IDX_EVT_ENABLE: prdata_r[N_EVT-1:0] <= ien_r;
               IDX_CHAN_MODE: prdata_r[SINGLE_BIT] <= single_r;
               IDX_LIVE_STATE: begin
                  prdata_r[LIVE_ACT_A_LSB +: 2] <= act_a_r;
                  prdata_r[LIVE_ACT_B_LSB +: 2] <= act_b_r;
                  prdata_r[LIVE_PIN_LSB +: N_FLAG] <= pin_r;
               end
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // config registers; reserved bits are not stored and read zero
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         i_thr_r <= RST_I_THRESH;
         q_thr_r <= RST_Q_THRESH;
         overrange_pin_config_r <= RST_OVERRANGE_PIN_CONFIG;
         mode_r <= RST_PRESET_MODE;
         sel_r <= RST_PRESET_SEL;
         ien_r <= '0;
         single_r <= 1'b0;
      end else if (wr_acc) begin
         case (idx)
            IDX_I_THRESH: i_thr_r <= i_pwdata[7:0];
            IDX_Q_THRESH: q_thr_r <= i_pwdata[7:0];
            IDX_OVERRANGE_PIN_CONFIG: overrange_pin_config_r <= {4'h0, i_pwdata[3:0]};
            IDX_PRESET_MODE: mode_r <= {6'h00, i_pwdata[1:0]};
            IDX_PRESET_SEL: sel_r <= {4'h0, i_pwdata[3:0]};
            IDX_EVT_ENABLE: ien_r <= i_pwdata[N_EVT-1:0];
            IDX_CHAN_MODE: single_r <= i_pwdata[SINGLE_BIT];
            default: single_r <= single_r;
         endcase
      end
   end

   // ---------------- over-range detection and pulse stretch
   assign samp[0] = i_samp_i_a;
   assign samp[1] = i_samp_q_a;
   assign samp[2] = i_samp_i_b;
   assign samp[3] = i_samp_q_b;
   assign stretch_len = PULSE_BASE << overrange_pin_config_r[PULSE_EXTENSION_EXPONENT_LSB +: PULSE_EXTENSION_EXPONENT_W];

   genvar k;
   generate
      for (k = 0; k < N_FLAG; k++) begin : g_flag
         // even flags watch I against its threshold, odd ones Q
         assign det[k] = i_sample_valid && (level9(samp[k]) >=
            {1'b0, ((k % 2) == 0) ? i_thr_r : q_thr_r});

         always_ff @(posedge i_clk_sys) begin
            if (i_srst) begin
               cnt_r[k] <= '0;
               pin_r[k] <= 1'b0;
            end else begin
               // retrigger restarts the full minimum window
               if (det[k]) begin
                  cnt_r[k] <= stretch_len - 1'b1;
               end else if (cnt_r[k] != '0) begin
                  cnt_r[k] <= cnt_r[k] - 1'b1;
               end
               // a pin rises only on a fresh detection, so enabling
               // mid-stretch never shows a short remainder
               pin_r[k] <= overrange_pin_config_r[OVERRANGE_PIN_ENABLE_BIT] &&
                  (det[k] || (pin_r[k] && (cnt_r[k] != '0)));
            end
         end
      end
   endgenerate

   // link bits follow detection directly, independent of pin enable
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         det_r <= '0;
      end else begin
         det_r <= det;
      end
   end

   // ---------------- preset selection
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pin_a_s1_r <= 2'h0;
         pin_a_s2_r <= 2'h0;
         pin_b_s1_r <= 2'h0;
         pin_b_s2_r <= 2'h0;
      end else begin
         pin_a_s1_r <= i_chan_a_preset_pins;
         pin_a_s2_r <= pin_a_s1_r;
         pin_b_s1_r <= i_chan_b_preset_pins;
         pin_b_s2_r <= pin_b_s1_r;
      end
   end

   always_comb begin
      act_a_nxt = act_a_r;
      act_b_nxt = act_b_r;
      case (orps_mode_e'(mode_r[MODE_LSB +: 2]))
         MODE_REG: begin
            act_a_nxt = sel_r[SEL_A_LSB +: 2];
            act_b_nxt = sel_r[SEL_B_LSB +: 2];
         end
         MODE_PINS_AB: begin
            act_a_nxt = pin_a_s2_r;
            act_b_nxt = pin_b_s2_r;
         end
         MODE_PINS_A: begin
            act_a_nxt = pin_a_s2_r;
            act_b_nxt = pin_a_s2_r;
         end
         // reserved code keeps the last active presets
         default: begin
            act_a_nxt = act_a_r;
            act_b_nxt = act_b_r;
         end
      endcase
      // single channel: converter B unused, it tracks A's choice
      if (single_r) begin
         act_b_nxt = act_a_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         act_a_r <= 2'h0;
         act_b_r <= 2'h0;
         o_osc_a_freq <= '0;
         o_osc_a_phase <= '0;
         o_osc_b_freq <= '0;
         o_osc_b_phase <= '0;
      end else begin
         act_a_r <= act_a_nxt;
         act_b_r <= act_b_nxt;
         o_osc_a_freq <= pick_f(i_conv_a_frequency_word, act_a_r);
         o_osc_a_phase <= pick_p(i_conv_a_phase_word, act_a_r);
         o_osc_b_freq <= pick_f(i_conv_b_frequency_word, act_b_r);
         o_osc_b_phase <= pick_p(i_conv_b_phase_word, act_b_r);
      end
   end

   // ---------------- interrupt: sticky status, set beats clear
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         stat_r <= '0;
         irq_r <= 1'b0;
      end else begin
         stat_r <= (stat_r & ~({N_EVT{clr_wr}} & i_pwdata[N_EVT-1:0])) |
            {(act_a_nxt != act_a_r) || (act_b_nxt != act_b_r), det};
         irq_r <= |(stat_r & ien_r);
      end
   end

   assign o_pready = pready_r;
   assign o_prdata = prdata_r;
   assign o_pslverr = pslverr_r;
   assign o_irq = irq_r;
   assign o_chan_a_range_flag_0 = pin_r[0];
   assign o_chan_a_range_flag_1 = pin_r[1];
   assign o_chan_b_range_flag_0 = pin_r[2];
   assign o_chan_b_range_flag_1 = pin_r[3];
   assign o_link_ovr_a = det_r[1:0];
   assign o_link_ovr_b = det_r[3:2];

endmodule : orps_overrange_preset

// ==== src/orps_pkg.sv ====
package orps_pkg;
   // register indices; byte address on apb is four times the index
   localparam int unsigned ADDR_W = 12;
   localparam logic [9:0] IDX_I_THRESH = 10'h211;
   localparam logic [9:0] IDX_Q_THRESH = 10'h212;
   localparam logic [9:0] IDX_OVERRANGE_PIN_CONFIG = 10'h213;
   localparam logic [9:0] IDX_PRESET_MODE = 10'h214;
   localparam logic [9:0] IDX_PRESET_SEL = 10'h215;
   localparam logic [9:0] IDX_EVT_STATUS = 10'h220;
   localparam logic [9:0] IDX_EVT_CLEAR = 10'h221;
   localparam logic [9:0] IDX_EVT_ENABLE = 10'h222;
   localparam logic [9:0] IDX_CHAN_MODE = 10'h223;
   localparam logic [9:0] IDX_LIVE_STATE = 10'h224;

   // reset values
   localparam logic [7:0] RST_I_THRESH = 8'hf2;
   localparam logic [7:0] RST_Q_THRESH = 8'hab;
   localparam logic [7:0] RST_OVERRANGE_PIN_CONFIG = 8'h07;
   localparam logic [7:0] RST_PRESET_MODE = 8'h00;
   localparam logic [7:0] RST_PRESET_SEL = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // field positions
   localparam int unsigned OVERRANGE_PIN_ENABLE_BIT = 3;
   localparam int unsigned PULSE_EXTENSION_EXPONENT_LSB = 0;
   localparam int unsigned PULSE_EXTENSION_EXPONENT_W = 3;
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned SEL_A_LSB = 0;
   localparam int unsigned SEL_B_LSB = 2;
   localparam int unsigned SINGLE_BIT = 0;
   localparam int unsigned LIVE_ACT_A_LSB = 0;
   localparam int unsigned LIVE_ACT_B_LSB = 2;
   localparam int unsigned LIVE_PIN_LSB = 4;

   // events: bits 0..3 over-range flags, bit 4 preset switch
   localparam int unsigned N_FLAG = 4;
   localparam int unsigned N_EVT = 5;
   localparam int unsigned EVT_PRESET = 4;

   // stretch length is PULSE_BASE << exponent device clock cycles
   localparam int unsigned CNT_W = 11;
   localparam logic [CNT_W-1:0] PULSE_BASE = 11'h008;

   typedef enum logic [1:0] {
      MODE_REG = 2'h0,
      MODE_PINS_AB = 2'h1,
      MODE_PINS_A = 2'h2,
      MODE_RSVD = 2'h3
   } orps_mode_e;
endpackage : orps_pkg

// ==== verif/orps_overrange_preset_asserts.sv ====
`timescale 1ns/1ps
module orps_overrange_preset_asserts (
   input wire logic i_clk_sys, // clock
   input wire logic i_srst, // reset
   input wire logic i_psel, // select
   input wire logic i_penable, // enable
   input wire logic o_pready, // ready
   input wire logic o_pslverr, // error
   input wire logic o_chan_a_range_flag_0, // pin A I
   input wire logic o_chan_a_range_flag_1, // pin A Q
   input wire logic o_chan_b_range_flag_0, // pin B I
   input wire logic o_chan_b_range_flag_1 // pin B Q
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   sequence setup_s;
      i_psel && !i_penable;
   endsequence
   sequence access_s;
      i_psel && i_penable && o_pready;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> access_s)
      else $error("no ready after setup");
   ready_once_a: assert property (access_s |=> !o_pready)
      else $error("ready held too long");
   ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
      else $error("ready without setup");
   err_with_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   hold_a0_a: assert property ($rose(o_chan_a_range_flag_0) |->
      o_chan_a_range_flag_0 [*8]) else $error("pin A I too short");
   hold_a1_a: assert property ($rose(o_chan_a_range_flag_1) |->
      o_chan_a_range_flag_1 [*8]) else $error("pin A Q too short");
   hold_b0_a: assert property ($rose(o_chan_b_range_flag_0) |->
      o_chan_b_range_flag_0 [*8]) else $error("pin B I too short");
   hold_b1_a: assert property ($rose(o_chan_b_range_flag_1) |->
      o_chan_b_range_flag_1 [*8]) else $error("pin B Q too short");
endmodule : orps_overrange_preset_asserts
bind orps_overrange_preset orps_overrange_preset_asserts chk_u (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_psel(i_psel),
   .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_chan_a_range_flag_0(o_chan_a_range_flag_0),
   .o_chan_a_range_flag_1(o_chan_a_range_flag_1),
   .o_chan_b_range_flag_0(o_chan_b_range_flag_0),
   .o_chan_b_range_flag_1(o_chan_b_range_flag_1));

// ==== verif/orps_far_ctrl.sv ====
`timescale 1ns/1ps
module orps_far_ctrl (
   input wire logic i_clk_sys, // clock
   input wire logic [1:0] i_want_a, // wanted preset A
   input wire logic [1:0] i_want_b, // wanted preset B
   input wire logic i_flag, // flag pin watched
   output logic [1:0] o_pins_a, // preset pins A
   output logic [1:0] o_pins_b, // preset pins B
   output int o_last_len // last flag width
);
   int run;
   initial begin
      o_pins_a = 2'h0;
      o_pins_b = 2'h0;
      o_last_len = 0;
      run = 0;
   end
   always @(posedge i_clk_sys) begin
      o_pins_a <= i_want_a;
      o_pins_b <= i_want_b;
      if (i_flag) begin
         run <= run + 1;
      end else if (run != 0) begin
         o_last_len <= run;
         run <= 0;
      end
   end
endmodule : orps_far_ctrl

// ==== verif/overrange_flag_and_nco_preset_select_tb.sv ====
`timescale 1ns/1ps
module overrange_flag_and_nco_preset_select_tb;
   import orps_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, fa, fb;
   logic pready, pslverr, vld = 1'b0, irq, err, fa0, fa1, fb0, fb1;
   logic [15:0] ia = 16'h0, qa = 16'h0, ib = 16'h0, qb = 16'h0, pa, pb;
   logic [1:0] want_a = 2'h0, want_b = 2'h0, pin_a, pin_b, la, lb;
   logic [1:0] acc_a, acc_b;
   logic [3:0] acc_f;
   int err_count = 0, num_checks = 0, flen;
   always #2 clk = ~clk;
   orps_far_ctrl far_u (.i_clk_sys(clk), .i_want_a(want_a),
      .i_want_b(want_b), .i_flag(fa0), .o_pins_a(pin_a),
      .o_pins_b(pin_b), .o_last_len(flen));
   orps_overrange_preset dut_u (.i_clk_sys(clk), .i_srst(rst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(4'hf), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_sample_valid(vld),
      .i_samp_i_a(ia), .i_samp_q_a(qa), .i_samp_i_b(ib), .i_samp_q_b(qb),
      .i_chan_a_preset_pins(pin_a), .i_chan_b_preset_pins(pin_b),
      .i_conv_a_frequency_word({32'ha3, 32'ha2, 32'ha1, 32'ha0}),
      .i_conv_a_phase_word({16'hc3, 16'hc2, 16'hc1, 16'hc0}),
      .i_conv_b_frequency_word({32'hb3, 32'hb2, 32'hb1, 32'hb0}),
      .i_conv_b_phase_word({16'hd3, 16'hd2, 16'hd1, 16'hd0}),
      .o_chan_a_range_flag_0(fa0), .o_chan_a_range_flag_1(fa1),
      .o_chan_b_range_flag_0(fb0), .o_chan_b_range_flag_1(fb1),
      .o_link_ovr_a(la), .o_link_ovr_b(lb), .o_osc_a_freq(fa),
      .o_osc_a_phase(pa), .o_osc_b_freq(fb), .o_osc_b_phase(pb),
      .o_irq(irq));
   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [9:0] idx,
      input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      // only the watchdog ends a wait that never sees ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // presets settle through the pin synchroniser within six edges
   task automatic osc(input int a, input int b);
      repeat (6) @(posedge clk);
      chk("osc_a_freq", fa, 32'ha0 + a);
      chk("osc_a_phase", {16'h0, pa}, 32'hc0 + a);
      chk("osc_b_freq", fb, 32'hb0 + b);
      chk("osc_b_phase", {16'h0, pb}, 32'hd0 + b);
   endtask : osc
   task automatic hit(input logic [15:0] v_ia, v_qa, v_ib);
      acc_a = 2'h0;
      acc_b = 2'h0;
      acc_f = 4'h0;
      @(posedge clk);
      vld <= 1'b1;
      ia <= v_ia;
      qa <= v_qa;
      ib <= v_ib;
      @(posedge clk);
      vld <= 1'b0;
      repeat (4) begin
         @(posedge clk);
         acc_a |= la;
         acc_b |= lb;
         acc_f |= {fb1, fb0, fa1, fa0};
      end
      repeat (40) @(posedge clk);
   endtask : hit
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial begin
      #100000;
      err_count++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(0, IDX_OVERRANGE_PIN_CONFIG, 0); chk("overrange_pin_config", rd, 32'h07);
      apb(0, IDX_PRESET_MODE, 0); chk("mode", rd, 32'h0);
      chk("mapped_err", {31'h0, err}, 32'h0);
      apb(0, IDX_I_THRESH, 0); chk("i_thresh", rd, 32'hf2);
      apb(0, IDX_Q_THRESH, 0); chk("q_thresh", rd, 32'hab);
      apb(0, 10'h3ff, 0); chk("unmapped", {31'h0, err}, 32'h1);
      apb(1, IDX_PRESET_SEL, 8'hff);
      apb(0, IDX_PRESET_SEL, 0); chk("sel", rd, 32'h0f);
      $display("test registers done");
      want_a <= 2'h2;
      for (int n = 0; n < 4; n++) begin
         apb(1, IDX_PRESET_SEL, 8'(((3 - n) << 2) | n));
         osc(n, 3 - n);
      end
      apb(1, IDX_PRESET_MODE, 8'h01);
      for (int n = 0; n < 4; n++) begin
         want_a <= 2'(n);
         want_b <= 2'(3 - n);
         osc(n, 3 - n);
      end
      apb(1, IDX_PRESET_MODE, 8'h02);
      for (int n = 0; n < 4; n++) begin
         want_a <= 2'(n);
         want_b <= 2'(3 - n);
         osc(n, n);
      end
      apb(1, IDX_PRESET_MODE, 8'h00);
      apb(1, IDX_CHAN_MODE, 8'h01);
      apb(1, IDX_PRESET_SEL, 8'h09);
      osc(1, 1);
      apb(1, IDX_PRESET_MODE, 8'h01);
      osc(3, 3);
      apb(1, IDX_CHAN_MODE, 8'h00);
      apb(1, IDX_PRESET_MODE, 8'h03);
      want_a <= 2'h1;
      want_b <= 2'h2;
      osc(3, 0);
      apb(0, IDX_LIVE_STATE, 0); chk("live", rd, 32'h03);
      apb(0, IDX_EVT_STATUS, 0); chk("preset_evt", rd, 32'h10);
      $display("test presets done");
      apb(1, IDX_OVERRANGE_PIN_CONFIG, 8'h00);
      apb(1, IDX_EVT_CLEAR, 8'h1f);
      hit(16'h6000, 16'h6000, 16'h8001);
      chk("link_a", acc_a, 2'b10);
      chk("link_b", acc_b, 2'b01);
      chk("pins_off", acc_f, 4'h0);
      apb(0, IDX_EVT_STATUS, 0); chk("status", rd, 32'h06);
      chk("irq_masked", irq, 1'b0);
      apb(1, IDX_EVT_ENABLE, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq_on", irq, 1'b1);
      apb(1, IDX_EVT_CLEAR, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq_clr", irq, 1'b0);
      apb(1, IDX_OVERRANGE_PIN_CONFIG, 8'h08);
      hit(16'h7fff, 16'h6000, 16'h8001);
      chk("pins_on", acc_f, 4'h7);
      chk("link_a_on", acc_a, 2'b11);
      chk("width_0", flen, 32'd8);
      apb(1, IDX_OVERRANGE_PIN_CONFIG, 8'h0a);
      hit(16'h7fff, 16'h0, 16'h0);
      chk("width_2", flen, 32'd32);
      $display("test flags done");
      conclude();
   end
endmodule : overrange_flag_and_nco_preset_select_tb
